// [logic/msr_top.sv]
// slot reset sequencer, slot status register and merged host interrupt
//
// Function
// - writing one to reset bit 0 or 1 starts that slot's reset; zero ignored
// - software started slot reset releases itself after 200 ms
// - reset register reads one per slot while its reset line is asserted
// - board reset asserts both slot reset lines together
// - reset register bits 15 to 2 read zero and ignore writes
// - missing acknowledge within 8 us declares a slot timeout and ends the cycle
// - timeout is not a bus error; it sets status bit 13 (B) or 12 (A)
// - a read ended by timeout returns all ones
// - enabled timeout interrupt stays pending until its status bit is cleared
// - writing one to status bit 13 or 12 clears that timeout; zero ignored
// - status bits 9 and 8 follow the slot error lines; writes ignored
// - status bits 3 to 0 show B req1, B req0, A req1, A req0
// - writing one to bits 3 to 0 clears only active edge mode requests
// - all enabled timeout, error and request sources merge onto one host interrupt
// - read in interrupt space runs acknowledge cycle; A1 selects request
// - slot access lights that slot's indicator for about 200 ms
// - control bits 7,6 enable requests; bits 5,4 pick level or edge
// - control bit 3 lets an active error line raise the interrupt
// - control bit 2 enables timeout interrupt; control clears on reset
`include "msr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module msr_top #(
    parameter int         RESET_CYCLES = `MSR_RESET_CYC,
    parameter int         LED_CYCLES   = `MSR_LED_CYC,
    parameter int         TMO_CYCLES   = `MSR_TMO_CYC,
    // revision value is arbitrary
    parameter logic [7:0] REVISION     = 8'h00
) (
    // clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    // local register port
    input  wire msr_pkg::msr_regbus_t  bus_in,
    output logic [15:0]                reg_rdata_out,
    // module cycle request and answer
    input  wire msr_pkg::msr_cyc_req_t cyc_in,
    output logic                       cyc_busy_out,
    output logic                       cyc_done_out,
    output logic                       cyc_timeout_out,
    output logic [15:0]                cyc_rdata_out,
    // slot pins
    output logic [1:0]                 slot_reset_n_out,
    output logic [1:0]                 slot_sel_n_out,
    output logic [1:0]                 slot_intsel_n_out,
    output logic                       slot_a1_out,
    output logic                       slot_rw_n_out,
    input  wire logic [1:0]            slot_ack_n_in,
    input  wire logic [1:0]            slot_error_n_in,
    input  wire logic [3:0]            slot_irq_n_in,
    input  wire logic [15:0]           slot_data_in,
    // indicators and host interrupt
    output logic [1:0]                 slot_led_out,
    output logic                       inta_n_out
);
    import msr_pkg::*;

    localparam int RCW = $clog2(RESET_CYCLES + 1);
    localparam int LCW = $clog2(LED_CYCLES + 1);
    localparam int TCW = $clog2(TMO_CYCLES + 1);

    // ------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // first stage is read only by the second
    logic [7:0]  sync_a;
    logic [7:0]  sync_b;
    logic [15:0] data_a;
    logic [15:0] data_b;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sync_a <= 8'hFF;
            sync_b <= 8'hFF;
        end else begin
            sync_a <= {slot_ack_n_in, slot_error_n_in, slot_irq_n_in};
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            data_a <= 16'h0000;
            data_b <= 16'h0000;
        end else begin
            data_a <= slot_data_in;
            data_b <= data_a;
        end
    end

    wire logic [3:0] irq_n_s = sync_b[3:0];
    wire logic [1:0] err_n_s = sync_b[5:4];
    wire logic [1:0] ack_n_s = sync_b[7:6];

    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    wire logic wr_ctrl_a = bus_in.wr && hit(bus_in.addr, `MSR_OFS_CTRL_A);
    wire logic wr_ctrl_b = bus_in.wr && hit(bus_in.addr, `MSR_OFS_CTRL_B);
    wire logic wr_reset  = bus_in.wr && hit(bus_in.addr, `MSR_OFS_RESET);
    wire logic wr_status = bus_in.wr && hit(bus_in.addr, `MSR_OFS_STATUS);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl [2];

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl[0] <= `MSR_CTRL_RST;
            ctrl[1] <= `MSR_CTRL_RST;
        end else begin
            if (wr_ctrl_a) begin
                ctrl[0] <= bus_in.wdata[7:0];
            end
            if (wr_ctrl_b) begin
                ctrl[1] <= bus_in.wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // module cycle engine
    // ------------------------------------------------------------
    msr_state_t     state;
    logic [TCW-1:0] tmo_cnt;
    logic           cyc_slot;
    logic           cyc_read;
    logic           tmo_pulse;
    logic           start_pulse;

    assign start_pulse  = cyc_in.start && (state == MSR_IDLE);
    assign cyc_busy_out = (state != MSR_IDLE);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state             <= MSR_IDLE;
            tmo_cnt           <= '0;
            cyc_slot          <= 1'b0;
            cyc_read          <= 1'b0;
            tmo_pulse         <= 1'b0;
            cyc_done_out      <= 1'b0;
            cyc_timeout_out   <= 1'b0;
            cyc_rdata_out     <= 16'h0000;
            slot_sel_n_out    <= 2'b11;
            slot_intsel_n_out <= 2'b11;
            slot_a1_out       <= 1'b0;
            slot_rw_n_out     <= 1'b1;
        end else begin
            tmo_pulse       <= 1'b0;
            cyc_done_out    <= 1'b0;
            cyc_timeout_out <= 1'b0;
            case (state)
                MSR_IDLE: begin
                    tmo_cnt <= '0;
                    if (cyc_in.start) begin
                        state    <= MSR_WAIT;
                        cyc_slot <= cyc_in.slot;
                        cyc_read <= cyc_in.read;
                        // interrupt space select and A1 request choice
                        slot_a1_out   <= cyc_in.a1;
                        slot_rw_n_out <= cyc_in.read;
                        if (cyc_in.intsp) begin
                            slot_intsel_n_out <= ~(2'b01 << cyc_in.slot);
                        end else begin
                            slot_sel_n_out <= ~(2'b01 << cyc_in.slot);
                        end
                    end
                end
                MSR_WAIT: begin
                    tmo_cnt <= tmo_cnt + 1'b1;
                    // an ack released by the previous cycle lingers two cycles in the sync
                    if (!ack_n_s[cyc_slot] && (tmo_cnt > TCW'(1))) begin
                        state             <= MSR_IDLE;
                        cyc_done_out      <= 1'b1;
                        cyc_rdata_out     <= cyc_read ? data_b : 16'h0000;
                        slot_sel_n_out    <= 2'b11;
                        slot_intsel_n_out <= 2'b11;
                        slot_rw_n_out     <= 1'b1;
                    end else if (tmo_cnt == TCW'(TMO_CYCLES - 1)) begin
                        state             <= MSR_IDLE;
                        tmo_pulse         <= 1'b1;
                        // reported as done, not as an error
                        cyc_done_out      <= 1'b1;
                        cyc_timeout_out   <= 1'b1;
                        // all ones on timed out read
                        cyc_rdata_out     <= cyc_read ? `MSR_TMO_DATA : 16'h0000;
                        slot_sel_n_out    <= 2'b11;
                        slot_intsel_n_out <= 2'b11;
                        slot_rw_n_out     <= 1'b1;
                    end
                end
                default: begin
                    state <= MSR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // per slot reset, indicator, timeout and request status
    // ------------------------------------------------------------
    wire logic [1:0] rst_act;
    wire logic [1:0] tmo_flag;
    wire logic [1:0] err_act;
    wire logic [3:0] req_stat;
    wire logic [3:0] req_en;
    wire logic [1:0] tmo_irq;
    wire logic [1:0] err_irq;

    genvar g;
    genvar j;
    generate
        for (g = 0; g < 2; g++) begin : g_slot
            logic [RCW-1:0] rcnt;
            logic           ract;
            logic [LCW-1:0] lcnt;
            logic           tflag;

            // timed reset; one restarts, zero ignored
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    rcnt <= RCW'(RESET_CYCLES - 1);
                    ract <= 1'b1;
                end else if (wr_reset && bus_in.wdata[g]) begin
                    rcnt <= RCW'(RESET_CYCLES - 1);
                    ract <= 1'b1;
                end else if (rcnt != '0) begin
                    rcnt <= rcnt - 1'b1;
                end else begin
                    ract <= 1'b0;
                end
            end

            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    lcnt <= '0;
                end else if (start_pulse && (cyc_in.slot == g)) begin
                    lcnt <= LCW'(LED_CYCLES);
                end else if (lcnt != '0) begin
                    lcnt <= lcnt - 1'b1;
                end
            end

            // sticky timeout; set wins over clear
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    tflag <= 1'b0;
                end else begin
                    tflag <= (tmo_pulse && (cyc_slot == g)) ||
                             (tflag && !(wr_status && bus_in.wdata[`MSR_SB_TMO + g]));
                end
            end

            assign rst_act[g]  = ract;
            assign tmo_flag[g] = tflag;
            assign err_act[g]  = ~err_n_s[g];
            // timeout interrupt gated by control bit 2
            assign tmo_irq[g]  = tflag && ctrl[g][`MSR_CB_TMO_EN];
            // error interrupt while enabled and line active
            assign err_irq[g]  = err_act[g] && ctrl[g][`MSR_CB_ERR_EN];

            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    slot_led_out[g]     <= 1'b0;
                    slot_reset_n_out[g] <= 1'b0;
                end else begin
                    slot_led_out[g]     <= (lcnt != '0);
                    slot_reset_n_out[g] <= ~ract;
                end
            end

            for (j = 0; j < 2; j++) begin : g_req
                localparam int K = 2 * g + j;
                logic prev_n;
                logic elat;
                wire logic edge_sel = ctrl[g][`MSR_CB_REQ0_EDGE + j];
                wire logic fall     = prev_n && !irq_n_s[K];
                // clear only an active edge mode request
                wire logic clr      = wr_status && bus_in.wdata[K] && edge_sel && elat;

                // edge latch; a new edge beats a clear
                always_ff @(posedge clk_sys_in) begin
                    if (rst_in) begin
                        prev_n <= 1'b1;
                        elat   <= 1'b0;
                    end else begin
                        prev_n <= irq_n_s[K];
                        elat   <= edge_sel && (fall || (elat && !clr));
                    end
                end

                // level shows the line, edge shows the latch
                assign req_stat[K] = edge_sel ? elat : ~irq_n_s[K];
                assign req_en[K]   = ctrl[g][`MSR_CB_REQ0_EN + j];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // merged host interrupt
    // ------------------------------------------------------------
    // registered so the pin never glitches while sources settle
    // all enabled sources onto one line
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            inta_n_out <= 1'b1;
        end else begin
            inta_n_out <= ~(|(req_stat & req_en) | |tmo_irq | |err_irq);
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (hit(bus_in.addr, `MSR_OFS_REV)) begin
            rd_mux = {8'h00, REVISION};
        end else if (hit(bus_in.addr, `MSR_OFS_CTRL_A)) begin
            rd_mux = {8'h00, ctrl[0]};
        end else if (hit(bus_in.addr, `MSR_OFS_CTRL_B)) begin
            rd_mux = {8'h00, ctrl[1]};
        end else if (hit(bus_in.addr, `MSR_OFS_RESET)) begin
            // reset state in the low bits, zero above
            rd_mux = {14'h0000, rst_act};
        end else if (hit(bus_in.addr, `MSR_OFS_STATUS)) begin
            rd_mux = {2'b00, tmo_flag, 2'b00, err_act, 4'h0, req_stat};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (bus_in.rd) begin
            reg_rdata_out <= rd_mux;
        end
    end

endmodule
`default_nettype wire

// [logic/msr_cfg.svh]
// constants of the slot reset, status and interrupt block
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
// register offsets on the local register port
`define MSR_OFS_REV        8'h00
`define MSR_OFS_CTRL_A     8'h02
`define MSR_OFS_CTRL_B     8'h04
`define MSR_OFS_RESET      8'h0A
`define MSR_OFS_STATUS     8'h0C
// control register fields
`define MSR_CB_REQ0_EN     6
`define MSR_CB_REQ0_EDGE   4
`define MSR_CB_ERR_EN      3
`define MSR_CB_TMO_EN      2
// status register field positions
`define MSR_SB_ERR         8
`define MSR_SB_TMO         12
// reset values and data answers
`define MSR_CTRL_RST       8'h00
`define MSR_TMO_DATA       16'hFFFF
// timing
`define MSR_CLK_NS         40
`define MSR_TMO_NS         8000
`define MSR_RESET_MS       200
`define MSR_LED_MS         200
`define MSR_TMO_CYC        ((`MSR_TMO_NS + `MSR_CLK_NS - 1) / `MSR_CLK_NS)
`define MSR_RESET_CYC      ((`MSR_RESET_MS * 1000000 + `MSR_CLK_NS - 1) / `MSR_CLK_NS)
`define MSR_LED_CYC        ((`MSR_LED_MS * 1000000) / `MSR_CLK_NS)
`endif

// [logic/msr_pkg.sv]
// types of the slot reset, status and interrupt block
`default_nettype none
package msr_pkg;
    // local register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } msr_regbus_t;
    // module cycle request from the host bridge
    typedef struct packed {
        logic        start;
        logic        slot;
        logic        read;
        logic        intsp;
        logic        a1;
    } msr_cyc_req_t;
    // module cycle engine states
    typedef enum logic [0:0] {
        MSR_IDLE,
        MSR_WAIT
    } msr_state_t;
endpackage
`default_nettype wire

// [tb/msr_top_asserts.sv]
// port assertions for the slot reset, status and interrupt block
`timescale 1ns/10ps
`default_nettype none
module msr_top_asserts #(
    parameter int RESET_CYCLES = 20,
    parameter int TMO_CYCLES   = 8
) (
    // clock, reset and register port
    input wire logic                  clk_sys_in,
    input wire logic                  rst_in,
    input wire msr_pkg::msr_regbus_t  bus_in,
    input wire logic [15:0]           reg_rdata_out,
    // module cycle port
    input wire msr_pkg::msr_cyc_req_t cyc_in,
    input wire logic                  cyc_busy_out,
    input wire logic                  cyc_done_out,
    input wire logic                  cyc_timeout_out,
    input wire logic [15:0]           cyc_rdata_out,
    // slot pins and host interrupt
    input wire logic [1:0]            slot_reset_n_out,
    input wire logic [1:0]            slot_intsel_n_out,
    input wire logic                  slot_a1_out,
    input wire logic                  slot_rw_n_out,
    input wire logic [1:0]            slot_ack_n_in,
    input wire logic [1:0]            slot_error_n_in,
    input wire logic [1:0]            slot_led_out,
    input wire logic                  inta_n_out
);
    import msr_pkg::*;
    // pipeline slack of three cycles either way around the reset length is legal
    localparam int RLO = RESET_CYCLES - 3;
    localparam int RHI = RESET_CYCLES + 3;
    // ack watch spans 8 cycles, the rest of the timeout is a fixed delay
    localparam int TW  = TMO_CYCLES - 8;
    logic err_en_a;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            err_en_a <= 1'b0;
        end else if (bus_in.wr && bus_in.addr == 8'h02) begin
            err_en_a <= bus_in.wdata[3];
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // --------------------
    // port relations
    // --------------------
    property p_rst_both; $fell(rst_in) |-> slot_reset_n_out == 2'b00; endproperty
    a_rst_both: assert property (p_rst_both)
        else $error("slot resets not asserted after board reset");
    property p_rst_start; bus_in.wr && bus_in.addr == 8'h0A && bus_in.wdata[0]
        |-> ##2 !slot_reset_n_out[0]; endproperty
    a_rst_start: assert property (p_rst_start)
        else $error("slot reset not started by write");
    property p_rst_auto; $fell(slot_reset_n_out[0])
        |-> ##[RLO:RHI] $rose(slot_reset_n_out[0]); endproperty
    a_rst_auto: assert property (p_rst_auto)
        else $error("slot reset not released after its period");
    property p_rst_read; bus_in.rd && !bus_in.wr && bus_in.addr == 8'h0A
        |=> reg_rdata_out == {14'h0000, ~slot_reset_n_out}; endproperty
    a_rst_read: assert property (p_rst_read)
        else $error("reset register read differs from reset lines");
    property p_tmo_time; $rose(cyc_busy_out) ##1 (slot_ack_n_in == 2'b11) [*8]
        |-> ##[TW:TW] (cyc_timeout_out && cyc_done_out); endproperty
    a_tmo_time: assert property (p_tmo_time)
        else $error("missing acknowledge did not end cycle in time");
    property p_tmo_data; cyc_timeout_out && $past(slot_rw_n_out)
        |-> cyc_rdata_out == 16'hFFFF; endproperty
    a_tmo_data: assert property (p_tmo_data)
        else $error("timed out read did not return all ones");
    property p_err_irq; (err_en_a && !slot_error_n_in[0]) [*4] |-> !inta_n_out; endproperty
    a_err_irq: assert property (p_err_irq)
        else $error("enabled error line did not interrupt");
    property p_led; cyc_in.start && !cyc_busy_out && !cyc_in.slot
        |-> ##2 slot_led_out[0] [*8]; endproperty
    a_led: assert property (p_led)
        else $error("access indicator not lit");
    property p_intsel; cyc_in.start && !cyc_busy_out && cyc_in.intsp && cyc_in.read
        |=> !slot_intsel_n_out[$past(cyc_in.slot)] && slot_a1_out == $past(cyc_in.a1);
    endproperty
    a_intsel: assert property (p_intsel)
        else $error("acknowledge cycle select or address wrong");
endmodule
bind msr_top msr_top_asserts #(.RESET_CYCLES(RESET_CYCLES), .TMO_CYCLES(TMO_CYCLES)) u_chk (
    .clk_sys_in, .rst_in, .bus_in, .reg_rdata_out, .cyc_in, .cyc_busy_out, .cyc_done_out,
    .cyc_timeout_out, .cyc_rdata_out, .slot_reset_n_out, .slot_intsel_n_out, .slot_a1_out,
    .slot_rw_n_out, .slot_ack_n_in, .slot_error_n_in, .slot_led_out, .inta_n_out);
`default_nettype wire

// [tb/msr_slot_model.sv]
// behavioural model of the two plug-in modules
`timescale 1ns/10ps
`default_nettype none
module msr_slot_model (
    // carrier side
    input  wire logic        clk_in,
    input  wire logic [1:0]  sel_n_in,
    input  wire logic [1:0]  intsel_n_in,
    input  wire logic        a1_in,
    // bench control
    input  wire logic [1:0]  mute_in,
    input  wire logic        slow_in,
    input  wire logic [1:0]  err_in,
    input  wire logic [3:0]  req_in,
    // module lines
    output logic [1:0]       ack_n_out,
    output logic [1:0]       error_n_out,
    output logic [3:0]       irq_n_out,
    output logic [15:0]      data_out
);
    logic [3:0] cnt  = 4'h0;
    logic [3:0] pend = 4'h0;
    logic [1:0] act;
    logic [1:0] iack;
    logic       rdy;
    assign act         = ~(sel_n_in & intsel_n_in);
    assign iack        = ~intsel_n_in & ~ack_n_out;
    assign rdy         = cnt >= (slow_in ? 4'h4 : 4'h1);
    assign error_n_out = ~err_in;
    assign irq_n_out   = ~pend;
    initial ack_n_out = 2'b11;
    initial data_out  = 16'h0000;
    always @(posedge clk_in) begin
        cnt       <= (act == 2'b00) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
        ack_n_out <= ~(act & ~mute_in & {2{rdy}});
        // released bus toggles so stale data never looks valid
        data_out  <= (act != 2'b00) ? (16'h0C50 | {14'h0000, act[1], a1_in}) : ~data_out;
        pend      <= (pend | req_in) & ~{iack[1] & a1_in, iack[1] & ~a1_in,
                                         iack[0] & a1_in, iack[0] & ~a1_in};
    end
endmodule
`default_nettype wire

// [tb/module_slot_reset_status_irq_tb.sv]
// self-checking bench for the slot reset, status and interrupt block
`timescale 1ns/10ps
`default_nettype none
module module_slot_reset_status_irq_tb;
    import msr_pkg::*;
    typedef struct packed { logic [7:0] a; logic [15:0] w; logic [15:0] e; } msr_row_t;
    localparam int RC = 20;
    localparam int LC = 30;
    msr_row_t rows [8] = '{
        '{8'h02, 16'hFFFF, 16'h00FF}, '{8'h04, 16'hFFFF, 16'h00FF},
        '{8'h02, 16'h0000, 16'h0000}, '{8'h04, 16'h0000, 16'h0000},
        '{8'h0A, 16'hFFFC, 16'h0000}, '{8'h0C, 16'hFFFF, 16'h0000},
        '{8'h06, 16'hFFFF, 16'h0000}, '{8'h0E, 16'h1234, 16'h0000}};
    logic          clk_sys_in = 1'b0;
    logic          rst_in     = 1'b1;
    msr_regbus_t   bus_in     = '0;
    msr_cyc_req_t  cyc_in     = '0;
    logic [15:0]   reg_rdata_out, cyc_rdata_out, slot_data_in, v;
    logic          cyc_busy_out, cyc_done_out, cyc_timeout_out, slot_a1_out;
    logic          slot_rw_n_out, inta_n_out, t;
    logic [1:0]    slot_reset_n_out, slot_sel_n_out, slot_intsel_n_out, slot_led_out;
    logic [1:0]    slot_ack_n_in, slot_error_n_in;
    logic [3:0]    slot_irq_n_in;
    logic [1:0]    mute = 2'b00;
    logic [1:0]    err  = 2'b00;
    logic [3:0]    req  = 4'h0;
    logic          slow = 1'b0;
    int            fail_count = 0;
    int            num_checks = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    msr_top #(.RESET_CYCLES(RC), .LED_CYCLES(LC), .TMO_CYCLES(8)) dut (
        .clk_sys_in, .rst_in, .bus_in, .reg_rdata_out, .cyc_in, .cyc_busy_out,
        .cyc_done_out, .cyc_timeout_out, .cyc_rdata_out, .slot_reset_n_out, .slot_sel_n_out,
        .slot_intsel_n_out, .slot_a1_out, .slot_rw_n_out, .slot_ack_n_in, .slot_error_n_in,
        .slot_irq_n_in, .slot_data_in, .slot_led_out, .inta_n_out);
    msr_slot_model u_mod (.clk_in(clk_sys_in), .sel_n_in(slot_sel_n_out),
        .intsel_n_in(slot_intsel_n_out), .a1_in(slot_a1_out), .mute_in(mute),
        .slow_in(slow), .err_in(err), .req_in(req), .ack_n_out(slot_ack_n_in),
        .error_n_out(slot_error_n_in), .irq_n_out(slot_irq_n_in), .data_out(slot_data_in));
    // --------------------
    // bus and compare tasks
    // --------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        step(1);
        bus_in = {a, 1'b1, 1'b0, d};
        step(1);
        bus_in = '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        step(1);
        bus_in = {a, 1'b0, 1'b1, 16'h0000};
        step(1);
        bus_in = '0;
        chk16(reg_rdata_out, e);
    endtask
    // reads only; write data to modules is not carried by this block
    task automatic mcyc(input logic s, input logic is, input logic a);
        step(1);
        cyc_in = {1'b1, s, 1'b1, is, a};
        step(1);
        cyc_in = '0;
        for (int i = 0; i < 40 && cyc_done_out !== 1'b1; i++) step(1);
        chk1(cyc_done_out, 1'b1);
        v = cyc_rdata_out;
        t = cyc_timeout_out;
    endtask
    task automatic raise(input int i);
        req = 4'h1 << i;
        step(1);
        req = 4'h0;
        step(4);
    endtask
    task automatic complete_run;
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        complete_run();
    end
    // --------------------
    // test sequence
    // --------------------
    initial begin
        step(20);
        rst_in = 1'b0;
        rdchk(8'h0A, 16'h0003);
        rdchk(8'h02, 16'h0000);
        rdchk(8'h04, 16'h0000);
        step(RC + 4);
        rdchk(8'h0A, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].e);
        end
        for (int s = 0; s < 2; s++) begin
            wr(8'h0A, 16'h0001 << s);
            rdchk(8'h0A, 16'h0001 << s);
            chk16({14'h0000, slot_reset_n_out}, 16'h0003 ^ (16'h0001 << s));
            step(RC + 4);
            chk16({14'h0000, slot_reset_n_out}, 16'h0003);
        end
        wr(8'h02, 16'h0004);
        mute = 2'b11;
        mcyc(1'b0, 1'b0, 1'b0);
        chk16(v, 16'hFFFF);
        chk1(t, 1'b1);
        chk1(slot_led_out[0], 1'b1);
        rdchk(8'h0C, 16'h1000);
        chk1(inta_n_out, 1'b0);
        wr(8'h0C, 16'h0000);
        rdchk(8'h0C, 16'h1000);
        wr(8'h0C, 16'h1000);
        rdchk(8'h0C, 16'h0000);
        chk1(inta_n_out, 1'b1);
        mcyc(1'b1, 1'b0, 1'b0);
        rdchk(8'h0C, 16'h2000);
        chk1(inta_n_out, 1'b1);
        wr(8'h0C, 16'h2000);
        step(LC);
        chk16({14'h0000, slot_led_out}, 16'h0000);
        mute = 2'b00;
        mcyc(1'b1, 1'b0, 1'b1);
        chk16(v, 16'h0C53);
        chk1(t, 1'b0);
        for (int i = 0; i < 4; i++) begin
            slow = i[0];
            wr(i[1] ? 8'h04 : 8'h02, 16'h0040 << i[0]);
            raise(i);
            rdchk(8'h0C, 16'h0001 << i);
            chk1(inta_n_out, 1'b0);
            mcyc(i[1], 1'b1, i[0]);
            chk16(v, 16'h0C50 | 16'(i));
            step(4);
            rdchk(8'h0C, 16'h0000);
            chk1(inta_n_out, 1'b1);
        end
        wr(8'h04, 16'h0000);
        wr(8'h02, 16'h0010);
        raise(0);
        rdchk(8'h0C, 16'h0001);
        chk1(inta_n_out, 1'b1);
        mcyc(1'b0, 1'b1, 1'b0);
        step(4);
        rdchk(8'h0C, 16'h0001);
        wr(8'h0C, 16'h0001);
        rdchk(8'h0C, 16'h0000);
        wr(8'h02, 16'h0040);
        raise(0);
        wr(8'h0C, 16'h0001);
        rdchk(8'h0C, 16'h0001);
        mcyc(1'b0, 1'b1, 1'b0);
        err = 2'b01;
        wr(8'h02, 16'h0000);
        step(4);
        rdchk(8'h0C, 16'h0100);
        chk1(inta_n_out, 1'b1);
        wr(8'h02, 16'h0008);
        wr(8'h0C, 16'h0300);
        rdchk(8'h0C, 16'h0100);
        chk1(inta_n_out, 1'b0);
        wr(8'h02, 16'h0000);
        step(2);
        chk1(inta_n_out, 1'b1);
        err = 2'b10;
        step(4);
        rdchk(8'h0C, 16'h0200);
        complete_run();
    end
endmodule
`default_nettype wire
